// ==== rtl/t8w_consts.vh ====
// constants for the 8-bit timer waveform block
`ifndef T8W_CONSTS_VH
`define T8W_CONSTS_VH
`define T8W_ADDR_CTRL 12'h000
`define T8W_ADDR_CMPA 12'h004
`define T8W_ADDR_COUNT 12'h008
`define T8W_ADDR_STATUS 12'h00C
`define T8W_CTRL_WS_LSB 0
`define T8W_CTRL_WS_MSB 2
`define T8W_CTRL_OAS_LSB 4
`define T8W_CTRL_OAS_MSB 5
`define T8W_CTRL_PS_LSB 8
`define T8W_CTRL_PS_MSB 10
`define T8W_CTRL_DIR_BIT 12
`define T8W_STAT_CMPA_BIT 0
`define T8W_STAT_OVF_BIT 1
`define T8W_STAT_DOWN_BIT 2
`define T8W_CTRL_RESET 13'h0000
`define T8W_BOTTOM 8'h00
`define T8W_MAX 8'hFF
`define T8W_WS_NORMAL 3'h0
`define T8W_WS_PC_FIXED 3'h1
`define T8W_WS_CTC 3'h2
`define T8W_WS_FAST_FIXED 3'h3
`define T8W_WS_PC_CMPA 3'h5
`define T8W_WS_FAST_CMPA 3'h7
`define T8W_OAS_NONE 2'h0
`define T8W_OAS_TOGGLE 2'h1
`define T8W_OAS_NONINV 2'h2
`define T8W_OAS_INV 2'h3
`define T8W_PS_STOP 3'h0
`define T8W_PS_DIV1 3'h1
`define T8W_PS_DIV8 3'h2
`define T8W_PS_DIV32 3'h3
`define T8W_PS_DIV64 3'h4
`define T8W_PS_DIV128 3'h5
`define T8W_PS_DIV256 3'h6
`define T8W_PS_DIV1024 3'h7
`define T8W_DIV_MASK8 10'h007
`define T8W_DIV_MASK32 10'h01F
`define T8W_DIV_MASK64 10'h03F
`define T8W_DIV_MASK128 10'h07F
`define T8W_DIV_MASK256 10'h0FF
`define T8W_DIV_MASK1024 10'h3FF
`endif

// ==== rtl/t8w_prescaler.v ====
// prescaler that makes the timer tick enable from the clock
`timescale 1ns/10ps
`include "t8w_consts.vh"
module t8w_prescaler (
   input wire clk,
   input wire rst_n,
   input wire [2:0] divSelect,
   output reg tick
);
   reg [9:0] divCnt_q;
   reg [9:0] mask;

   always @* begin
      case (divSelect)
         `T8W_PS_DIV1: mask = 10'h000;
         `T8W_PS_DIV8: mask = `T8W_DIV_MASK8;
         `T8W_PS_DIV32: mask = `T8W_DIV_MASK32;
         `T8W_PS_DIV64: mask = `T8W_DIV_MASK64;
         `T8W_PS_DIV128: mask = `T8W_DIV_MASK128;
         `T8W_PS_DIV256: mask = `T8W_DIV_MASK256;
         default: mask = `T8W_DIV_MASK1024;
      endcase
   end

   // tick is one clock wide, once every N clocks; stop selection gives none
   always @(posedge clk) begin
      if (!rst_n) begin
         divCnt_q <= 10'h000;
         tick <= 1'b0;
      end else if (divSelect == `T8W_PS_STOP) begin
         divCnt_q <= 10'h000;
         tick <= 1'b0;
      end else begin
         divCnt_q <= divCnt_q + 10'h001;
         tick <= ((divCnt_q & mask) == mask);
      end
   end
endmodule // t8w_prescaler

// ==== rtl/t8w_timer.v ====
// 8-bit timer with clear-on-match, fast and phase-correct waveform modes, APB slave
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "t8w_consts.vh"
module t8w_timer (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire cmpAAck,
   input wire ovfAck,
   output reg cmpAFlag,
   output reg ovfFlag,
   output reg waveOutA,
   output reg waveOutAOe
);
   ////////////////////////////////////////////////////////////////////////////
   // register state
   reg [12:0] ctrl_q;
   reg [7:0] cmpA_q;
   reg [7:0] cmpBuf_q;
   reg [7:0] count_q;
   reg countDown_q;
   reg matchPend_q;
   reg blockMatch_q;
   reg wave_q;
   reg [7:0] count_d;
   reg countDown_d;
   reg wave_d;
   reg [7:0] cmpA_d;
   reg ovfSet;
   wire tick;

   wire [2:0] waveSel = ctrl_q[`T8W_CTRL_WS_MSB:`T8W_CTRL_WS_LSB];
   wire [1:0] actSel = ctrl_q[`T8W_CTRL_OAS_MSB:`T8W_CTRL_OAS_LSB];
   wire [2:0] divSel = ctrl_q[`T8W_CTRL_PS_MSB:`T8W_CTRL_PS_LSB];
   wire dirOut = ctrl_q[`T8W_CTRL_DIR_BIT];

   wire modeCtc = (waveSel == `T8W_WS_CTC);
   wire modeFast = (waveSel == `T8W_WS_FAST_FIXED) || (waveSel == `T8W_WS_FAST_CMPA);
   wire modePc = (waveSel == `T8W_WS_PC_FIXED) || (waveSel == `T8W_WS_PC_CMPA);
   wire modePwm = modeFast || modePc;
   wire topIsCmp = (waveSel == `T8W_WS_FAST_CMPA) || (waveSel == `T8W_WS_PC_CMPA);
   wire [7:0] topVal = topIsCmp ? cmpA_q : `T8W_MAX;
   wire atTop = (count_q == topVal);
   wire atBottom = (count_q == `T8W_BOTTOM);
   // a count write blocks the match of the following tick
   wire matchA = (count_q == cmpA_q) && !blockMatch_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire setupPh = psel && !penable;
   wire accWrite = psel && penable && pready && pwrite;
   wire wrCtrl = accWrite && (paddr == `T8W_ADDR_CTRL);
   wire wrCmp = accWrite && (paddr == `T8W_ADDR_CMPA);
   wire wrCount = accWrite && (paddr == `T8W_ADDR_COUNT);
   wire wrStat = accWrite && (paddr == `T8W_ADDR_STATUS);
   wire mapped = (paddr == `T8W_ADDR_CTRL) || (paddr == `T8W_ADDR_CMPA) ||
                 (paddr == `T8W_ADDR_COUNT) || (paddr == `T8W_ADDR_STATUS);
   reg [31:0] rdMux;

   always @* begin
      case (paddr)
         `T8W_ADDR_CTRL: rdMux = {19'h00000, ctrl_q};
         `T8W_ADDR_CMPA: rdMux = {24'h000000, cmpBuf_q};
         `T8W_ADDR_COUNT: rdMux = {24'h000000, count_q};
         `T8W_ADDR_STATUS: rdMux = {29'h00000000, countDown_q, ovfFlag, cmpAFlag};
         default: rdMux = 32'h00000000;
      endcase
   end

   // no wait state: answer formed in the setup cycle, pready high in the first access cycle
   reg [31:0] prdata_d;
   reg pready_d;
   reg pslverr_d;

   always @* begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata;
      if (setupPh) begin
         pready_d = 1'b1;
         pslverr_d = !mapped;
         prdata_d = rdMux;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= pready_d;
         pslverr <= pslverr_d;
         prdata <= prdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tick source
   t8w_prescaler uPrescale (
      .clk(clk),
      .rst_n(rst_n),
      .divSelect(divSel),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // counter and waveform next state, evaluated for a tick
   always @* begin
      count_d = count_q;
      countDown_d = countDown_q;
      wave_d = wave_q;
      cmpA_d = cmpA_q;
      ovfSet = 1'b0;
      if (modeCtc) begin
         if (atBottom && !blockMatch_q && (count_q != cmpA_q)) begin
            count_d = count_q + 8'h01;
         end
         if (matchA) begin
            count_d = `T8W_BOTTOM;
         end else begin
            count_d = count_q + 8'h01;
         end
         ovfSet = (count_q == `T8W_MAX) && !matchA;
         if (matchA && (actSel == `T8W_OAS_TOGGLE)) begin
            wave_d = !wave_q;
         end else if (matchA && (actSel == `T8W_OAS_NONINV)) begin
            wave_d = 1'b0;
         end else if (matchA && (actSel == `T8W_OAS_INV)) begin
            wave_d = 1'b1;
         end
      end else if (modeFast) begin
         countDown_d = 1'b0;
         if (atTop) begin
            count_d = `T8W_BOTTOM;
            ovfSet = 1'b1;
            cmpA_d = cmpBuf_q;
         end else begin
            count_d = count_q + 8'h01;
         end
         // top-to-bottom action wins over a match at top, so MAX gives a steady level
         if (atTop && (actSel == `T8W_OAS_NONINV)) begin
            wave_d = 1'b1;
         end else if (atTop && (actSel == `T8W_OAS_INV)) begin
            wave_d = 1'b0;
         end else if (matchA) begin
            case (actSel)
               `T8W_OAS_TOGGLE: wave_d = !wave_q;
               `T8W_OAS_NONINV: wave_d = 1'b0;
               `T8W_OAS_INV: wave_d = 1'b1;
               default: wave_d = wave_q;
            endcase
         end
      end else if (modePc) begin
         if (!countDown_q) begin
            if (atTop) begin
               countDown_d = 1'b1;
               count_d = count_q - 8'h01;
               cmpA_d = cmpBuf_q;
            end else begin
               count_d = count_q + 8'h01;
            end
         end else begin
            if (atBottom) begin
               countDown_d = 1'b0;
               count_d = count_q + 8'h01;
               ovfSet = 1'b1;
            end else begin
               count_d = count_q - 8'h01;
            end
         end
         if (countDown_q && atBottom) begin
            // bottom forces the level a down match gives, or the up level for 0
            if (actSel == `T8W_OAS_NONINV) begin
               wave_d = (cmpA_q != `T8W_BOTTOM);
            end else if (actSel == `T8W_OAS_INV) begin
               wave_d = (cmpA_q == `T8W_BOTTOM);
            end
         end else if (matchA && !(cmpA_q == `T8W_MAX)) begin
            // a match at top counts as an up match; compare at MAX holds level
            if (actSel == `T8W_OAS_NONINV) begin
               wave_d = countDown_q;
            end else if (actSel == `T8W_OAS_INV) begin
               wave_d = !countDown_q;
            end
         end
      end else begin
         count_d = count_q + 8'h01;
         ovfSet = (count_q == `T8W_MAX);
         if (matchA) begin
            case (actSel)
               `T8W_OAS_TOGGLE: wave_d = !wave_q;
               `T8W_OAS_NONINV: wave_d = 1'b0;
               `T8W_OAS_INV: wave_d = 1'b1;
               default: wave_d = wave_q;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes; the compare buffer takes every write
   reg [12:0] ctrl_d;
   reg [7:0] cmpBuf_d;

   always @* begin
      ctrl_d = ctrl_q;
      cmpBuf_d = cmpBuf_q;
      if (wrCtrl) begin
         ctrl_d = pwdata[12:0];
      end
      if (wrCmp) begin
         cmpBuf_d = pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequential state
   always @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= `T8W_CTRL_RESET;
         cmpA_q <= `T8W_BOTTOM;
         cmpBuf_q <= `T8W_BOTTOM;
         count_q <= `T8W_BOTTOM;
         countDown_q <= 1'b0;
         matchPend_q <= 1'b0;
         blockMatch_q <= 1'b0;
         wave_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         cmpBuf_q <= cmpBuf_d;
         if (wrCmp && !modePwm) begin
            cmpA_q <= pwdata[7:0];
         end else if (tick && modePwm) begin
            cmpA_q <= cmpA_d;
         end
         if (wrCount) begin
            count_q <= pwdata[7:0];
            blockMatch_q <= 1'b1;
         end else if (tick) begin
            count_q <= count_d;
            blockMatch_q <= 1'b0;
         end
         if (tick) begin
            countDown_q <= countDown_d;
            wave_q <= wave_d;
            matchPend_q <= matchA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags and pin; a set in the same cycle as a clear wins
   wire cmpSet = tick && matchPend_q;
   wire cmpClr = cmpAAck || (wrStat && pwdata[`T8W_STAT_CMPA_BIT]);
   wire ovfSetT = tick && ovfSet;
   wire ovfClr = ovfAck || (wrStat && pwdata[`T8W_STAT_OVF_BIT]);

   reg cmpAFlag_d;
   reg ovfFlag_d;
   reg waveOutA_d;
   reg waveOutAOe_d;

   always @* begin
      cmpAFlag_d = cmpAFlag;
      if (cmpSet) begin
         cmpAFlag_d = 1'b1;
      end else if (cmpClr) begin
         cmpAFlag_d = 1'b0;
      end
   end

   always @* begin
      ovfFlag_d = ovfFlag;
      if (ovfSetT) begin
         ovfFlag_d = 1'b1;
      end else if (ovfClr) begin
         ovfFlag_d = 1'b0;
      end
   end

   // the pin is driven only while the direction bit selects output
   always @* begin
      waveOutA_d = wave_q;
      waveOutAOe_d = 1'b0;
      if (dirOut && (actSel != `T8W_OAS_NONE)) begin
         waveOutAOe_d = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         cmpAFlag <= 1'b0;
         ovfFlag <= 1'b0;
         waveOutA <= 1'b0;
         waveOutAOe <= 1'b0;
      end else begin
         cmpAFlag <= cmpAFlag_d;
         ovfFlag <= ovfFlag_d;
         waveOutA <= waveOutA_d;
         waveOutAOe <= waveOutAOe_d;
      end
   end
endmodule // t8w_timer

// ==== test/t8w_pin_load.sv ====
// load on the waveform pin
`timescale 1ns/10ps
module t8w_pin_load (
   input wire clk,
   input wire waveOutA,
   input wire waveOutAOe,
   output logic pinLevel
);
   logic last_q = 1'b0;
   always @(posedge clk) last_q <= pinLevel;
   // undriven pin floats: show the inverse of the last level
   assign pinLevel = waveOutAOe ? waveOutA : ~last_q;
endmodule // t8w_pin_load

// ==== test/t8w_timer_properties.sv ====
// port assertions for the timer
`timescale 1ns/10ps
module t8w_timer_props (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire cmpAAck,
   input wire ovfAck,
   input wire cmpAFlag,
   input wire ovfFlag,
   input wire waveOutA,
   input wire waveOutAOe
);
   logic cmpClr_q;
   logic ovfClr_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // clear causes, one clock late
   always @(posedge clk) begin
      cmpClr_q <= cmpAAck || (pready && pwrite && paddr == 12'h00C && pwdata[0]);
      ovfClr_q <= ovfAck || (pready && pwrite && paddr == 12'h00C && pwdata[1]);
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ctrl_wr;
      pready && psel && pwrite && paddr == 12'h000;
   endsequence
   property p_ack;
      s_setup |=> pready ##1 !pready;
   endproperty
   property p_idle;
      !psel |=> !pready;
   endproperty
   property p_err;
      pready && paddr > 12'h00C |-> pslverr;
   endproperty
   property p_err_data;
      pready && pslverr |-> prdata == 32'h0000_0000;
   endproperty
   property p_cmp_clr;
      $fell(cmpAFlag) |-> cmpClr_q;
   endproperty
   property p_ovf_clr;
      $fell(ovfFlag) |-> ovfClr_q;
   endproperty
   property p_oe_off;
      s_ctrl_wr ##0 !pwdata[12] |-> ##[1:2] !waveOutAOe;
   endproperty
   property p_oe_on;
      s_ctrl_wr ##0 (pwdata[12] && pwdata[5:4] != 2'h0) |-> ##[1:2] waveOutAOe;
   endproperty
   a_ack: assert property (p_ack) else $error("no single ready after setup");
   a_idle: assert property (p_idle) else $error("ready without select");
   a_err: assert property (p_err) else $error("unmapped access not refused");
   a_err_data: assert property (p_err_data) else $error("refused read data not zero");
   a_cmp_clr: assert property (p_cmp_clr) else $error("compare flag fell uncaused");
   a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag fell uncaused");
   a_oe_off: assert property (p_oe_off) else $error("pin driven with input direction");
   a_oe_on: assert property (p_oe_on) else $error("pin not driven with output direction");
endmodule // t8w_timer_props
bind t8w_timer t8w_timer_props t8w_timer_props_i (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cmpAAck(cmpAAck), .ovfAck(ovfAck),
   .cmpAFlag(cmpAFlag), .ovfFlag(ovfFlag), .waveOutA(waveOutA), .waveOutAOe(waveOutAOe));

// ==== test/tb_top.sv ====
// testbench for the timer waveform block
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmpAAck = 1'b0, ovfAck = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, cmpAFlag, ovfFlag, waveOutA, waveOutAOe, pinLevel, se;
   int err_count = 0, check_count = 0;
   always #2 clk = ~clk;
   t8w_timer t8w_timer_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmpAAck(cmpAAck), .ovfAck(ovfAck), .cmpAFlag(cmpAFlag),
      .ovfFlag(ovfFlag), .waveOutA(waveOutA), .waveOutAOe(waveOutAOe));
   t8w_pin_load t8w_pin_load_i (.clk(clk), .waveOutA(waveOutA), .waveOutAOe(waveOutAOe),
      .pinLevel(pinLevel));
   task complete_run;
      $display("TB: %0d checks, %0d mismatches", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         complete_run;
      end
   endtask
   task waitPin(input logic lvl, inout int n);
      while (pinLevel !== lvl && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) begin
         err_count++;
         complete_run;
      end
   endtask
   function logic [31:0] mk(input logic [2:0] ws, input logic [1:0] oas, input logic [2:0] ps);
      return {19'h0, 1'b1, 1'b0, ps, 2'h0, oas, 1'b0, ws};
   endfunction
   // per 0: count high cycles in a fixed window instead of timing edges
   task runWave(input logic [31:0] ctrl, input logic [7:0] cmp, input int per, input int hi);
      int n, p, h;
      apb(1'b1, 12'h004, {24'h0, cmp});
      apb(1'b1, 12'h000, ctrl);
      repeat (1100) @(posedge clk);
      n = 0;
      p = 0;
      h = 0;
      if (per == 0) begin
         repeat (600) begin
            @(posedge clk);
            h += (pinLevel === 1'b1);
         end
      end else begin
         waitPin(1'b0, n);
         waitPin(1'b1, n);
         waitPin(1'b0, p);
         h = p;
         waitPin(1'b1, p);
         chk(p, per);
      end
      chk(h, hi);
      $display("TB: wave test ctrl=%h cmp=%h done", ctrl, cmp);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      chk({waveOutA, waveOutAOe, cmpAFlag, ovfFlag}, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(se, 32'h1);
      chk(rd, 32'h0);
      $display("TB: register test done");
      runWave(mk(3'h2, 2'h1, 3'h1), 8'h02, 6, 3);
      runWave(mk(3'h2, 2'h1, 3'h2), 8'h02, 48, 24);
      runWave(mk(3'h2, 2'h1, 3'h1), 8'h00, 2, 1);
      apb(1'b1, 12'h000, mk(3'h2, 2'h0, 3'h0));
      apb(1'b1, 12'h008, 32'h50);
      apb(1'b1, 12'h004, 32'h10);
      apb(1'b1, 12'h000, mk(3'h2, 2'h0, 3'h1));
      // clear after the start: a match left from the last run sets the flag on the first tick
      apb(1'b1, 12'h00C, 32'h3);
      repeat (150) @(posedge clk);
      chk({cmpAFlag, ovfFlag}, 32'h0);
      repeat (90) @(posedge clk);
      chk({cmpAFlag, ovfFlag}, 32'h3);
      apb(1'b1, 12'h000, mk(3'h2, 2'h0, 3'h0));
      // the last tick still lands one clock after the stop
      repeat (2) @(posedge clk);
      cmpAAck <= 1'b1;
      @(posedge clk);
      cmpAAck <= 1'b0;
      repeat (20) @(posedge clk);
      chk({cmpAFlag, ovfFlag}, 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h10);
      apb(1'b1, 12'h00C, 32'h2);
      @(posedge clk);
      chk(ovfFlag, 32'h0);
      $display("TB: flag test done");
      runWave(mk(3'h3, 2'h2, 3'h1), 8'h40, 256, 65);
      apb(1'b1, 12'h00C, 32'h2);
      repeat (300) @(posedge clk);
      chk(ovfFlag, 32'h1);
      apb(1'b1, 12'h000, mk(3'h3, 2'h2, 3'h0));
      repeat (2) @(posedge clk);
      ovfAck <= 1'b1;
      @(posedge clk);
      ovfAck <= 1'b0;
      @(posedge clk);
      chk(ovfFlag, 32'h0);
      runWave(mk(3'h3, 2'h3, 3'h1), 8'h40, 256, 191);
      runWave(mk(3'h3, 2'h1, 3'h1), 8'h40, 512, 256);
      runWave(mk(3'h7, 2'h1, 3'h1), 8'h40, 130, 65);
      runWave(mk(3'h1, 2'h2, 3'h1), 8'h40, 510, 128);
      runWave(mk(3'h1, 2'h3, 3'h1), 8'h40, 510, 382);
      runWave(mk(3'h5, 2'h2, 3'h1), 8'h40, 128, 64);
      runWave(mk(3'h3, 2'h2, 3'h1), 8'hFF, 0, 600);
      runWave(mk(3'h3, 2'h2, 3'h1), 8'h00, 256, 1);
      runWave(mk(3'h1, 2'h2, 3'h1), 8'h00, 0, 0);
      runWave(mk(3'h1, 2'h2, 3'h1), 8'hFF, 0, 600);
      apb(1'b1, 12'h000, 32'h0000_0022);
      repeat (3) @(posedge clk);
      chk(waveOutAOe, 32'h0);
      $display("TB: pin test done");
      complete_run;
   end
endmodule // tb_top
